// >>> common/udpd_pkg.sv
package udpd_pkg;

   // Clock of the device core and of the host
   localparam int CLK_PERIOD_NS = 5;

   // Entry command opcode
   localparam logic [7:0] OPC_UDPD_ENTER = 8'h79;
   localparam int BYTE_BITS = 8;

   // Link timing, in ns
   localparam int UDPD_ENTRY_DELAY_NS = 3000;
   localparam int UDPD_EXIT_DELAY_NS = 3000;
   localparam int WAKE_PULSE_LOW_TIME_NS = 20;
   localparam int CS_DESELECT_NS = 30;

   // Longest times round down, least times round up, never below one cycle
   localparam int UDPD_ENTRY_DELAY_CYC =
      (UDPD_ENTRY_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (UDPD_ENTRY_DELAY_NS / CLK_PERIOD_NS);
   localparam int UDPD_EXIT_DELAY_CYC =
      (UDPD_EXIT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (UDPD_EXIT_DELAY_NS / CLK_PERIOD_NS);
   localparam int WAKE_PULSE_LOW_CYC =
      ((WAKE_PULSE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
      ((WAKE_PULSE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int CS_DESELECT_CYC =
      ((CS_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
      ((CS_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Host serial clock half period in core cycles
   localparam int SCLK_HALF_CYC = 2;

   // Select pin edge to the synced edge the core acts on, in core cycles
   localparam int SYNC_CYC = 3;

   localparam int TIMER_W = 16;
   localparam int REQ_BITS_W = 6;

endpackage : udpd_pkg

// >>> common/udpd_if.sv
`timescale 1ns/1ps
interface udpd_if;
   logic cs_n;
   logic sclk;
   logic serial_in;

   modport dev (
      input cs_n,
      input sclk,
      input serial_in
   );

   modport host (
      output cs_n,
      output sclk,
      output serial_in
   );
endinterface : udpd_if

// >>> verilog/udpd_device.sv
`timescale 1ns/1ps
// Function
// - Ignore every command while in ultra-deep power-down
// - Entry only from deep power-down, opcode 79h
// - Bits after the entry opcode are ignored
// - Enter ultra-deep power-down within entry delay
// - Misaligned or short frame aborts to standby
// - Power cycle always starts in standby
// - Entry ignored while program or erase busy
// - Host reissues entry after busy operation ends
// - Select low pulse of minimum time wakes
// - Dummy byte during wake pulse is ignored
// - Back in standby within exit delay
// - Select low during exit delay is ignored
// - Host waits for standby before normal commands
module udpd_device #(
   parameter int ENTRY_CYC = udpd_pkg::UDPD_ENTRY_DELAY_CYC,
   parameter int EXIT_CYC = udpd_pkg::UDPD_EXIT_DELAY_CYC,
   parameter int WAKE_CYC = udpd_pkg::WAKE_PULSE_LOW_CYC
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   udpd_if.dev link,
   input wire logic in_dpd_in,
   input wire logic busy_in,
   output logic udpd_out,
   output logic cmd_ignore_out,
   output logic standby_ret_out,
   output logic entry_busy_out
);
   import udpd_pkg::*;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_ENTER,
      ST_UDPD,
      ST_WAKE,
      ST_EXIT
   } udpd_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: runs only on serial clock edges inside a frame

   logic frame_rst_n;
   logic link_act_ff;
   logic frame_tog_ff;
   logic [2:0] bit_cnt_ff;
   logic got_byte_ff;
   logic [7:0] opc_ff;
   // Select high ends the frame without needing a clock edge
   assign frame_rst_n = nrst_in & ~link.cs_n;

   always_ff @(posedge link.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         link_act_ff <= 1'b0;
      end else begin
         link_act_ff <= 1'b1;
      end
   end

   // Toggles once per frame that saw at least one clock edge
   always_ff @(posedge link.sclk or negedge nrst_in) begin
      if (!nrst_in) begin
         frame_tog_ff <= 1'b0;
      end else if (!link_act_ff) begin
         frame_tog_ff <= ~frame_tog_ff;
      end
   end

   always_ff @(posedge link.sclk or negedge nrst_in) begin
      if (!nrst_in) begin
         bit_cnt_ff <= 3'h0;
      end else if (!link_act_ff) begin
         bit_cnt_ff <= 3'h1;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge link.sclk or negedge nrst_in) begin
      if (!nrst_in) begin
         got_byte_ff <= 1'b0;
      end else if (!link_act_ff) begin
         got_byte_ff <= 1'b0;
      end else if (bit_cnt_ff == 3'h7) begin
         got_byte_ff <= 1'b1;
      end
   end

   // Shifting stops after the first byte, later bits never reach the opcode
   always_ff @(posedge link.sclk or negedge nrst_in) begin
      if (!nrst_in) begin
         opc_ff <= 8'h00;
      end else if (!link_act_ff) begin
         opc_ff <= {7'h00, link.serial_in};
      end else if (!got_byte_ff) begin
         opc_ff <= {opc_ff[6:0], link.serial_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the core clock

   logic cs_meta_ff;
   logic cs_sync_ff;
   logic cs_prev_ff;
   logic tog_meta_ff;
   logic tog_sync_ff;
   logic tog_seen_ff;
   logic cs_rise;
   logic cs_fall;
   logic had_bits;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cs_meta_ff <= 1'b1;
         cs_sync_ff <= 1'b1;
         cs_prev_ff <= 1'b1;
      end else begin
         cs_meta_ff <= link.cs_n;
         cs_sync_ff <= cs_meta_ff;
         cs_prev_ff <= cs_sync_ff;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tog_meta_ff <= 1'b0;
         tog_sync_ff <= 1'b0;
      end else begin
         tog_meta_ff <= frame_tog_ff;
         tog_sync_ff <= tog_meta_ff;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tog_seen_ff <= 1'b0;
      end else if (cs_rise) begin
         tog_seen_ff <= tog_sync_ff;
      end
   end

   assign cs_rise = cs_sync_ff & ~cs_prev_ff;
   assign cs_fall = ~cs_sync_ff & cs_prev_ff;
   assign had_bits = tog_sync_ff != tog_seen_ff;

   // Opcode and count are read only at the synced select rise: the serial
   // clock is quiet by then, so the link-domain values stand still
   logic entry_cmd;
   logic entry_aligned;
   assign entry_cmd = had_bits && got_byte_ff && (opc_ff == OPC_UDPD_ENTER);
   assign entry_aligned = bit_cnt_ff == 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Power state

   udpd_state_type state_ff;
   udpd_state_type nxt_state;
   logic [TIMER_W-1:0] timer_ff;
   logic ignore_frame_ff;
   logic wake_long;
   logic entry_go;
   assign wake_long = (timer_ff + TIMER_W'(1)) >= TIMER_W'(WAKE_CYC);
   assign entry_go = entry_cmd && entry_aligned && in_dpd_in && !busy_in && !ignore_frame_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_STANDBY: begin
            if (cs_rise && entry_go) begin
               nxt_state = ST_ENTER;
            end
         end
         ST_ENTER: begin
            // Counted from the select pin, so the synchroniser delay is part of the bound
            if (timer_ff + TIMER_W'(SYNC_CYC + 1) >= TIMER_W'(ENTRY_CYC)) begin
               nxt_state = ST_UDPD;
            end
         end
         ST_UDPD: begin
            if (cs_fall) begin
               nxt_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (cs_rise) begin
               nxt_state = wake_long ? ST_EXIT : ST_UDPD;
            end
         end
         ST_EXIT: begin
            if (timer_ff + TIMER_W'(SYNC_CYC + 1) >= TIMER_W'(EXIT_CYC)) begin
               nxt_state = ST_STANDBY;
            end
         end
         default: begin
            nxt_state = ST_STANDBY;
         end
      endcase
   end

   // Reset is the power cycle, so it always lands in standby
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff <= ST_STANDBY;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // One timer serves entry, wake low time and exit; saturates
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         timer_ff <= '0;
      end else if (nxt_state != state_ff) begin
         timer_ff <= '0;
      end else if (timer_ff != '1) begin
         timer_ff <= timer_ff + TIMER_W'(1);
      end
   end

   // A frame begun while entering or exiting is dropped whole
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ignore_frame_ff <= 1'b0;
      end else if (cs_fall && (state_ff == ST_ENTER || state_ff == ST_EXIT)) begin
         ignore_frame_ff <= 1'b1;
      end else if (cs_rise) begin
         ignore_frame_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         udpd_out <= 1'b0;
      end else begin
         udpd_out <= nxt_state == ST_UDPD || nxt_state == ST_WAKE || nxt_state == ST_EXIT;
      end
   end

   // Core decode must drop every frame while this is high, status reads too
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_ignore_out <= 1'b0;
      end else begin
         cmd_ignore_out <= nxt_state != ST_STANDBY
            || (cs_fall && state_ff != ST_STANDBY)
            || (ignore_frame_ff && !cs_rise);
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         standby_ret_out <= 1'b0;
      end else begin
         standby_ret_out <= (state_ff == ST_EXIT && nxt_state == ST_STANDBY)
            || (state_ff == ST_STANDBY && cs_rise && entry_cmd && !entry_aligned
                && in_dpd_in && !busy_in && !ignore_frame_ff);
      end
   end

   // Busy core: command dropped, nothing changes; host must resend
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         entry_busy_out <= 1'b0;
      end else begin
         entry_busy_out <= state_ff == ST_STANDBY && cs_rise && entry_cmd
            && in_dpd_in && busy_in && !ignore_frame_ff;
      end
   end

endmodule : udpd_device

// >>> verilog/udpd_host.sv
`timescale 1ns/1ps
module udpd_host #(
   parameter int HALF_CYC = udpd_pkg::SCLK_HALF_CYC,
   parameter int WAKE_CYC = udpd_pkg::WAKE_PULSE_LOW_CYC,
   parameter int EXIT_CYC = udpd_pkg::UDPD_EXIT_DELAY_CYC,
   parameter int GAP_CYC = udpd_pkg::CS_DESELECT_CYC
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   udpd_if.host link,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [7:0] req_byte_in,
   input wire logic [udpd_pkg::REQ_BITS_W-1:0] req_bits_in,
   input wire logic req_wake_in,
   output logic done_out
);
   import udpd_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE,
      H_LEAD,
      H_LOW,
      H_HIGH,
      H_TAIL,
      H_GAP
   } udpd_host_state_type;

   udpd_host_state_type state_ff;
   logic [TIMER_W-1:0] cnt_ff;
   logic [TIMER_W-1:0] low_cnt_ff;
   logic [TIMER_W-1:0] gap_len_ff;
   logic [REQ_BITS_W-1:0] bits_ff;
   logic [7:0] shift_ff;
   logic half_done;

   assign half_done = cnt_ff >= TIMER_W'(HALF_CYC - 1);
   assign req_ready_out = state_ff == H_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencing

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff <= H_IDLE;
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + TIMER_W'(1);
         case (state_ff)
            H_IDLE: begin
               cnt_ff <= '0;
               if (req_valid_in) begin
                  state_ff <= H_LEAD;
               end
            end
            H_LEAD: begin
               if (half_done) begin
                  cnt_ff <= '0;
                  state_ff <= (bits_ff == '0) ? H_TAIL : H_LOW;
               end
            end
            H_LOW: begin
               if (half_done) begin
                  cnt_ff <= '0;
                  state_ff <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (half_done) begin
                  cnt_ff <= '0;
                  state_ff <= (bits_ff == REQ_BITS_W'(1)) ? H_TAIL : H_LOW;
               end
            end
            H_TAIL: begin
               // Select stays low for the wake time even with few bits
               if (half_done && low_cnt_ff >= TIMER_W'(WAKE_CYC)) begin
                  cnt_ff <= '0;
                  state_ff <= H_GAP;
               end
            end
            H_GAP: begin
               // After a wake pulse, ready returns only once the exit delay is over
               if (cnt_ff >= gap_len_ff) begin
                  state_ff <= H_IDLE;
               end
            end
            default: begin
               state_ff <= H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gap_len_ff <= '0;
      end else if (state_ff == H_IDLE && req_valid_in) begin
         gap_len_ff <= req_wake_in ? TIMER_W'(EXIT_CYC) : TIMER_W'(GAP_CYC);
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         low_cnt_ff <= '0;
      end else if (state_ff == H_IDLE || state_ff == H_GAP) begin
         low_cnt_ff <= '0;
      end else if (low_cnt_ff != '1) begin
         low_cnt_ff <= low_cnt_ff + TIMER_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data, MSB first; zeros follow once the byte is out

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bits_ff <= '0;
         shift_ff <= 8'h00;
      end else if (state_ff == H_IDLE && req_valid_in) begin
         bits_ff <= req_bits_in;
         shift_ff <= req_byte_in;
      end else if (state_ff == H_HIGH && half_done) begin
         bits_ff <= bits_ff - REQ_BITS_W'(1);
         shift_ff <= {shift_ff[6:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins, all from flip-flops

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.serial_in <= 1'b0;
         done_out <= 1'b0;
      end else begin
         link.cs_n <= !(state_ff == H_LEAD || state_ff == H_LOW || state_ff == H_HIGH
            || state_ff == H_TAIL || (state_ff == H_IDLE && req_valid_in));
         link.sclk <= state_ff == H_HIGH && !half_done || state_ff == H_LOW && half_done;
         link.serial_in <= shift_ff[7];
         done_out <= state_ff == H_GAP && cnt_ff >= gap_len_ff;
      end
   end

endmodule : udpd_host

// >>> dv/udpd_monitor.sv
`timescale 1ns/1ps
module udpd_monitor #(
   parameter int ENTRY_CYC = udpd_pkg::UDPD_ENTRY_DELAY_CYC,
   parameter int EXIT_CYC = udpd_pkg::UDPD_EXIT_DELAY_CYC
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic in_dpd_in,
   input wire logic busy_in,
   input wire logic udpd_out,
   input wire logic cmd_ignore_out,
   input wire logic standby_ret_out,
   input wire logic entry_busy_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   // Cycles since select last rose, saturating; a frame begun during the
   // exit delay must not restart the count
   logic cs_q_ff;
   logic [15:0] hi_cnt_ff;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cs_q_ff <= 1'h1;
         hi_cnt_ff <= 16'h0000;
      end else begin
         cs_q_ff <= cs_n;
         if (cs_n && !cs_q_ff) begin
            hi_cnt_ff <= 16'h0001;
         end else if (hi_cnt_ff != 16'hFFFF) begin
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_reset_standby: assert property ($rose(nrst_in) |-> !udpd_out && !cmd_ignore_out)
      else $error("not in standby after reset");
   a_entry_delay_bound: assert property ($rose(udpd_out) |-> hi_cnt_ff inside {[ENTRY_CYC - 2:ENTRY_CYC]})
      else $error("entry outside delay window");
   a_entry_from_dpd: assert property ($rose(udpd_out) |-> in_dpd_in && !busy_in)
      else $error("entry without idle deep power-down");
   a_busy_refuse: assert property (entry_busy_out |-> !udpd_out ##1 (!entry_busy_out && !udpd_out))
      else $error("entry taken while busy");
   a_exit_delay_bound: assert property ($fell(udpd_out) |-> hi_cnt_ff inside {[EXIT_CYC - 2:EXIT_CYC]})
      else $error("exit outside delay window");
   a_exit_ret_pulse: assert property ($fell(udpd_out) |-> standby_ret_out || $past(standby_ret_out))
      else $error("exit without standby pulse");
   a_ret_single: assert property (standby_ret_out |=> !standby_ret_out && !udpd_out)
      else $error("standby pulse malformed");
   a_frame_ignored: assert property (udpd_out && !cs_n |-> ##[0:4] cmd_ignore_out)
      else $error("frame not ignored in deep state");
   a_sclk_framed: assert property ($rose(sclk) |-> !cs_n)
      else $error("clock edge outside frame");
   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("clock not idle low");
   a_data_held: assert property (sclk |-> $stable(serial_in))
      else $error("data moved while clock high");
endmodule : udpd_monitor

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   import udpd_pkg::*;
   localparam int ENT = 8;
   localparam int EXI = 24;
   logic clock_in, nrst_in, in_dpd_in, busy_in, req_valid_in, req_wake_in;
   logic [7:0] req_byte_in;
   logic [REQ_BITS_W-1:0] req_bits_in;
   logic udpd_out, cmd_ignore_out, standby_ret_out, entry_busy_out, req_ready_out, done_out;
   logic saw_ret, saw_busy, saw_ign;
   logic [7:0] rx_byte;
   int rx_bits, cycles, num_errors, checks;

   udpd_if link ();
   udpd_device #(.ENTRY_CYC(ENT), .EXIT_CYC(EXI)) u_udpd_device (.clock_in(clock_in), .nrst_in(nrst_in),
      .link(link), .in_dpd_in(in_dpd_in), .busy_in(busy_in), .udpd_out(udpd_out),
      .cmd_ignore_out(cmd_ignore_out), .standby_ret_out(standby_ret_out), .entry_busy_out(entry_busy_out));
   udpd_host #(.EXIT_CYC(EXI)) u_udpd_host (.clock_in(clock_in), .nrst_in(nrst_in), .link(link),
      .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_byte_in(req_byte_in),
      .req_bits_in(req_bits_in), .req_wake_in(req_wake_in), .done_out(done_out));
   udpd_monitor #(.ENTRY_CYC(ENT), .EXIT_CYC(EXI)) u_udpd_monitor (.clock_in(clock_in), .nrst_in(nrst_in),
      .cs_n(link.cs_n), .sclk(link.sclk), .serial_in(link.serial_in), .in_dpd_in(in_dpd_in),
      .busy_in(busy_in), .udpd_out(udpd_out), .cmd_ignore_out(cmd_ignore_out),
      .standby_ret_out(standby_ret_out), .entry_busy_out(entry_busy_out));

   always #(CLK_PERIOD_NS / 2.0) clock_in = ~clock_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Wire watcher: first byte MSB first, rising clock edges counted while select is low
   always @(posedge link.sclk) begin
      if (!link.cs_n) begin
         if (rx_bits < 8) rx_byte = {rx_byte[6:0], link.serial_in};
         rx_bits = rx_bits + 1;
      end
   end

   always @(posedge clock_in) begin
      cycles = cycles + 1;
      if (standby_ret_out === 1'h1) saw_ret = 1'h1;
      if (entry_busy_out === 1'h1) saw_busy = 1'h1;
      if (!link.cs_n && cmd_ignore_out === 1'h1) saw_ign = 1'h1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         report_and_stop();
      end
   end

   task report_and_stop;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   ////////////////////////////////////////////////////////////////////////////////
   // One host frame up to done, no settling time after it
   task frame(input logic [7:0] b, input int bits, input logic wake);
      int n;
      @(posedge clock_in);
      rx_bits = 0;
      saw_ret = 1'h0;
      saw_busy = 1'h0;
      saw_ign = 1'h0;
      req_valid_in <= 1'h1;
      req_byte_in <= b;
      req_bits_in <= bits[REQ_BITS_W-1:0];
      req_wake_in <= wake;
      @(posedge clock_in);
      req_valid_in <= 1'h0;
      n = 0;
      while (done_out !== 1'h1 && n < 2000) begin
         @(posedge clock_in);
         n = n + 1;
      end
      if (n == 2000) check("done_out", 8'h01, 8'h00);
   endtask : frame

   // One host frame, then time for the device to decode and settle
   task send(input logic [7:0] b, input int bits, input logic wake);
      frame(b, bits, wake);
      repeat (ENT + 8) @(posedge clock_in);
   endtask : send

   task enter_udpd;
      send(OPC_UDPD_ENTER, 8, 1'h0);
      check("wire opcode", OPC_UDPD_ENTER, rx_byte);
      check("wire bits", 8'h08, rx_bits[7:0]);
      check("udpd after entry", 8'h01, udpd_out);
   endtask : enter_udpd

   task t_wake(input logic [7:0] b, input int bits);
      send(b, bits, 1'h1);
      check("ignore during pulse", 8'h01, saw_ign);
      check("standby pulse", 8'h01, saw_ret);
      check("udpd after wake", 8'h00, udpd_out);
      check("ignore after wake", 8'h00, cmd_ignore_out);
   endtask : t_wake

   task t_no_dpd;
      in_dpd_in <= 1'h0;
      send(OPC_UDPD_ENTER, 8, 1'h0);
      check("udpd from standby", 8'h00, udpd_out);
      in_dpd_in <= 1'h1;
   endtask : t_no_dpd

   task t_entry_busy;
      busy_in <= 1'h1;
      send(OPC_UDPD_ENTER, 8, 1'h0);
      check("busy refusal", 8'h01, saw_busy);
      check("udpd while busy", 8'h00, udpd_out);
      busy_in <= 1'h0;
      enter_udpd();
   endtask : t_entry_busy

   // Twelve bits abort, sixteen bits enter with the tail ignored
   task t_frame_length;
      send(OPC_UDPD_ENTER, 12, 1'h0);
      check("abort pulse", 8'h01, saw_ret);
      check("udpd misaligned", 8'h00, udpd_out);
      send(OPC_UDPD_ENTER, 16, 1'h0);
      check("wire bits long", 8'h10, rx_bits[7:0]);
      check("udpd long frame", 8'h01, udpd_out);
   endtask : t_frame_length

   // Select falls again inside the exit delay: that whole frame is dropped
   task t_exit_ignore;
      enter_udpd();
      frame(8'h00, 0, 1'h0);
      send(OPC_UDPD_ENTER, 8, 1'h0);
      check("ignore during exit", 8'h01, saw_ign);
      check("udpd after dropped frame", 8'h00, udpd_out);
      check("ignore after exit", 8'h00, cmd_ignore_out);
   endtask : t_exit_ignore

   task t_reset_mid;
      enter_udpd();
      nrst_in <= 1'h0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'h1;
      @(posedge clock_in);
      check("udpd after reset", 8'h00, udpd_out);
      check("ignore after reset", 8'h00, cmd_ignore_out);
   endtask : t_reset_mid

   initial begin
      clock_in = 1'h0;
      nrst_in = 1'h1;
      in_dpd_in = 1'h0;
      busy_in = 1'h0;
      req_valid_in = 1'h0;
      req_wake_in = 1'h0;
      req_byte_in = 8'h00;
      req_bits_in = '0;
      {saw_ret, saw_busy, saw_ign} = 3'h0;
      rx_byte = 8'h00;
      {rx_bits, cycles, num_errors, checks} = '0;
      // A definite falling edge, so every async-reset flop sees it
      #1;
      nrst_in = 1'h0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'h1;
      @(posedge clock_in);
      check("udpd at start", 8'h00, udpd_out);
      t_no_dpd();
      t_entry_busy();
      t_wake(8'h00, 0);
      enter_udpd();
      t_wake(8'hA5, 8);
      t_frame_length();
      t_wake(8'hFF, 8);
      t_exit_ignore();
      t_reset_mid();
      report_and_stop();
   end
endmodule : testbench
